// ### rtl/pbd_bank_divider.sv
/*
  Output-side logic of a phase-locked clock driver: shared divide-by-two and
  divide-by-four counter, glitch-free bank select, enable gating, divider clear,
  test bypass and a small Avalon-MM register slave.
  Assumes ref_clk_i is the oscillator clock; the device pins are asynchronous to it, rstn_i and the Avalon-MM bus are not.
*/
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module pbd_bank_divider #(
  parameter int BANK_WIDTH = pbd_pkg::BANK_WIDTH
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ref_clock_pair_p_i,
  input wire logic ref_clock_pair_n_i,
  input wire logic loop_feedback_in_i,
  input wire logic bank_select_hi_i,
  input wire logic bank_select_lo_i,
  input wire logic output_enable_n_i,
  input wire logic half_rate_clear_n_i,
  input wire logic test_bypass_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [BANK_WIDTH-1:0] bank1_out_o,
  output logic [BANK_WIDTH-1:0] bank2_out_o,
  output logic [BANK_WIDTH-1:0] bank3_out_o,
  output logic [BANK_WIDTH-1:0] bank4_out_o
);

  typedef enum logic [1:0] {
    PBD_ALL_FAST = 2'b00,
    PBD_SLOW_1 = 2'b01,
    PBD_SLOW_12 = 2'b10,
    PBD_SLOW_123 = 2'b11
  } pbd_sel_type;

  // true when bank (1..3) takes the quarter-rate clock under this code
  function automatic logic bank_is_slow(input pbd_sel_type code, input logic [1:0] bank);
    logic slow;
    slow = 1'b0;
    case (code)
      PBD_ALL_FAST: slow = 1'b0;
      PBD_SLOW_1: slow = (bank == 2'h1);
      PBD_SLOW_12: slow = (bank == 2'h1) || (bank == 2'h2);
      PBD_SLOW_123: slow = 1'b1;
      default: slow = 1'b0;
    endcase
    return slow;
  endfunction

  // two-stage synchronisers; stage one feeds only stage two
  logic [7:0] sync_meta;
  logic [7:0] sync_hold;
  logic ref_p_s;
  logic ref_n_s;
  logic fb_s;
  logic sel_hi_s;
  logic sel_lo_s;
  logic oe_n_s;
  logic clr_n_s;
  logic test_s;
  logic clr_n_prev;
  logic clear_fall;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sync_meta <= pbd_pkg::SYNC_IDLE;
      sync_hold <= pbd_pkg::SYNC_IDLE;
    end else begin
      sync_meta <= {ref_clock_pair_p_i, ref_clock_pair_n_i, loop_feedback_in_i,
                    bank_select_hi_i, bank_select_lo_i, output_enable_n_i,
                    half_rate_clear_n_i, test_bypass_i};
      sync_hold <= sync_meta;
    end
  end

  assign {ref_p_s, ref_n_s, fb_s, sel_hi_s, sel_lo_s, oe_n_s, clr_n_s, test_s} = sync_hold;

  // only the falling edge of clear acts; a held low level does nothing more
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      clr_n_prev <= 1'b1;
    end else begin
      clr_n_prev <= clr_n_s;
    end
  end

  assign clear_fall = clr_n_prev && !clr_n_s;

  // register slave
  logic ctrl_ovr;
  pbd_sel_type ctrl_sel;
  logic bus_ack;
  logic bus_req;

  assign bus_req = avs_read_i || avs_write_i;
  // one wait cycle per access keeps the read path registered
  assign avs_waitrequest_o = bus_req && !bus_ack;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctrl_ovr <= pbd_pkg::CTRL_RESET[pbd_pkg::CTRL_OVR_BIT];
      ctrl_sel <= pbd_sel_type'(pbd_pkg::SEL_ALL_FAST);
    end else if (avs_write_i && bus_ack && avs_address_i == pbd_pkg::CTRL_OFFSET) begin
      ctrl_ovr <= avs_writedata_i[pbd_pkg::CTRL_OVR_BIT];
      ctrl_sel <= pbd_sel_type'(avs_writedata_i[pbd_pkg::CTRL_SEL_LSB +: 2]);
    end
  end

  // shared counter and applied select
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  pbd_sel_type want_sel;
  pbd_sel_type applied_sel;

  assign next_cnt = clear_fall ? pbd_pkg::CNT_ZERO : 2'(cnt + pbd_pkg::CNT_ONE);
  assign want_sel = ctrl_ovr ? ctrl_sel : pbd_sel_type'({sel_hi_s, sel_lo_s});

  // one counter drives both rates, so quarter-rate edges land on half-rate edges
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt <= pbd_pkg::CNT_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end

  // swap the mux only when the next phase has both clocks low
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      applied_sel <= pbd_sel_type'(pbd_pkg::SEL_ALL_FAST);
    end else if (cnt == pbd_pkg::CNT_PRE_LOW && !clear_fall) begin
      applied_sel <= want_sel;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= pbd_pkg::READ_ZERO;
    end else if (avs_read_i && !bus_ack) begin
      case (avs_address_i)
        pbd_pkg::CTRL_OFFSET: begin
          avs_readdata_o <= {29'h0000_0000, ctrl_sel, ctrl_ovr};
        end
        pbd_pkg::STATUS_OFFSET: begin
          avs_readdata_o <= {24'h00_0000, !clr_n_s, fb_s, test_s, oe_n_s, cnt, applied_sel};
        end
        default: begin
          avs_readdata_o <= pbd_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // output stage: registered from the next counter phase
  logic half_clk;
  logic quarter_clk;
  logic ref_level;
  logic out_en;

  assign half_clk = !next_cnt[0];
  assign quarter_clk = !next_cnt[1];
  // bypass path: the raw differential reference replaces the divided clocks
  assign ref_level = ref_p_s && !ref_n_s;
  assign out_en = !oe_n_s;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      bank1_out_o <= '0;
      bank2_out_o <= '0;
      bank3_out_o <= '0;
      bank4_out_o <= '0;
    end else if (!out_en) begin
      bank1_out_o <= '0;
      bank2_out_o <= '0;
      bank3_out_o <= '0;
      bank4_out_o <= '0;
    end else if (test_s) begin
      bank1_out_o <= {BANK_WIDTH{ref_level}};
      bank2_out_o <= {BANK_WIDTH{ref_level}};
      bank3_out_o <= {BANK_WIDTH{ref_level}};
      bank4_out_o <= {BANK_WIDTH{ref_level}};
    end else begin
      // slow banks halve the fed-back rate, fast ones match it
      bank1_out_o <= {BANK_WIDTH{bank_is_slow(applied_sel, 2'h1) ? quarter_clk : half_clk}};
      bank2_out_o <= {BANK_WIDTH{bank_is_slow(applied_sel, 2'h2) ? quarter_clk : half_clk}};
      bank3_out_o <= {BANK_WIDTH{bank_is_slow(applied_sel, 2'h3) ? quarter_clk : half_clk}};
      bank4_out_o <= {BANK_WIDTH{half_clk}};
    end
  end

  // checks
  logic run_ok;
  assign run_ok = out_en && !test_s && !clear_fall;

  counter_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !$past(clear_fall) && $past(rstn_i) |-> cnt == 2'($past(cnt) + 2'h1))
    else $error("divider counter skipped a phase");

  clear_phase_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clear_fall |=> cnt == pbd_pkg::CNT_ZERO)
    else $error("clear edge did not reset divider phase");

  enable_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    oe_n_s |=> (bank1_out_o | bank2_out_o | bank3_out_o | bank4_out_o) == '0)
    else $error("outputs not low while disabled");

  bank4_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    run_ok ##1 run_ok |=> bank4_out_o[0] != $past(bank4_out_o[0]))
    else $error("fourth bank not at half rate");

  slow_duty_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    run_ok [*4] ##0 (applied_sel == PBD_SLOW_123 && $rose(bank3_out_o[0]))
    ##0 run_ok [*1] ##1 run_ok |-> bank3_out_o[0] ##1 !bank3_out_o[0])
    else $error("quarter-rate output duty not balanced");

  sel_window_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $changed(applied_sel) && $past(rstn_i) |-> $past(cnt) == pbd_pkg::CNT_PRE_LOW)
    else $error("bank select applied outside the low phase");

  test_path_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    out_en && test_s |=> bank2_out_o == {BANK_WIDTH{$past(ref_level)}})
    else $error("bypass path did not follow reference");

  fast_code_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    run_ok && applied_sel == PBD_ALL_FAST && !$changed(applied_sel)
    |=> bank1_out_o == bank4_out_o)
    else $error("code 00 left a bank slow");

  edge_align_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    run_ok ##1 run_ok ##1 (run_ok && $rose(bank3_out_o[0])) |-> $rose(bank4_out_o[0]))
    else $error("slow rising edge not on a fast rising edge");

  bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");

  slow_all_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    applied_sel == PBD_SLOW_123 && run_ok);
  clear_hit_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clear_fall && cnt == pbd_pkg::CNT_PRE_LOW);
  test_mode_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    out_en && test_s);
  override_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_ovr && $changed(applied_sel));

endmodule

// ### rtl/pbd_pkg.sv
/*
  Package for the bank divider select block: divider phases, select codes,
  register map of the Avalon-MM slave and bank geometry.
  Assumes one clock standing in for the oscillator, synchronous active-low reset.
*/
// Overview of operation
// - oscillator clock divided by two and four; these feed the banks unless test bypass is on
// - every divided output clock has 50% duty whatever the reference duty
// - two select inputs choose half- or quarter-rate clock per bank
// - codes 01,10,11 slow bank one, one-two, one-three; 00 all fast
// - with half-rate feedback, slow banks run at half the reference
// - half-rate feedback locks oscillator at twice the reference frequency
// - quarter-rate feedback gives outputs at reference or twice reference
// - oscillator runs 100 to 200 MHz, twice the output range
// - output enable high holds all outputs low; low lets them toggle
// - falling edge of clear resets half-rate setting outputs; level ignored
// - test input bypasses the loop; tied low in normal use
// - fourth bank carries the half-rate divided clock under every select code
// - clear resets the quarter-rate divider phase
// - test high drives outputs through bypass path, low from the loop
package pbd_pkg;
  localparam int BANK_WIDTH = 3;
  localparam int CNT_WIDTH = 2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  // phase just before the one in which both divided clocks are low
  localparam logic [1:0] CNT_PRE_LOW = 2'h2;
  localparam logic [1:0] SEL_ALL_FAST = 2'h0;
  localparam logic [1:0] SEL_BANK1 = 2'h1;
  localparam logic [1:0] SEL_BANK12 = 2'h2;
  localparam logic [1:0] SEL_BANK123 = 2'h3;
  localparam int ADDR_WIDTH = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int ST_SEL_LSB = 0;
  localparam int ST_CNT_LSB = 2;
  localparam int ST_OE_N_BIT = 4;
  localparam int ST_TEST_BIT = 5;
  localparam int ST_FB_BIT = 6;
  localparam int ST_CLR_BIT = 7;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // synchroniser reset value: the clear pin idles high, so releasing reset is no falling edge
  localparam logic [7:0] SYNC_IDLE = 8'h02;
endpackage

// ### testbench/pbd_bank_divider_select_tb.sv
/*
  Self-checking bench: pin sequences and Avalon-MM accesses with expected values.
  Assumes the design checks its own timing with embedded assertions.
*/
`timescale 1ns/1ps
module pbd_bank_divider_select_tb;
  logic clk, rstn, rp, rn, fb, shi, slo, oe_n, clr_n, tst, rd, wr, wreq;
  logic [3:0] addr;
  logic [31:0] wdat, rdat, got;
  logic [2:0] b1, b2, b3, b4;
  int n_fail, num_checks, rises, r0;
  pbd_bank_divider pbd_bank_divider_i (.ref_clk_i(clk), .rstn_i(rstn),
    .ref_clock_pair_p_i(rp), .ref_clock_pair_n_i(rn), .loop_feedback_in_i(fb),
    .bank_select_hi_i(shi), .bank_select_lo_i(slo), .output_enable_n_i(oe_n),
    .half_rate_clear_n_i(clr_n), .test_bypass_i(tst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .bank1_out_o(b1),
    .bank2_out_o(b2), .bank3_out_o(b3), .bank4_out_o(b4));
  pbd_load_model pbd_load_model_i (.ref_clk_i(clk), .fed_back_i(b4[0]),
    .loop_feedback_o(fb), .rise_count_o(rises));
  // clk stands for the oscillator: the reference is this rate over two with
  // half-rate feedback and over four with quarter-rate feedback
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // master holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] s, input logic o, input logic t, input logic c);
    @(posedge clk);
    {shi, slo} <= s;
    oe_n <= o;
    tst <= t;
    clr_n <= c;
    repeat (8) @(posedge clk); // settle time after any control change
  endtask
  // fast banks follow bank4; a slow bank holds while bank4 is low and
  // flips at each bank4 rise, giving 2 high 2 low aligned with it
  task automatic clocks(input logic [2:0] slow);
    logic [3:0] v, p1, p2, e;
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      v = {b4[0], b3[0], b2[0], b1[0]};
      chk("bits", 32'({{3{v[3]}}, {3{v[2]}}, {3{v[1]}}, {3{v[0]}}}), 32'({b4, b3, b2, b1}));
      e[3] = ~p1[3];
      for (int i = 0; i < 3; i++) begin
        e[i] = slow[i] ? (v[3] ? ~p2[i] : p1[i]) : v[3];
      end
      if (k >= 2) begin
        chk("banks", 32'(e), 32'(v));
      end
      p2 = p1;
      p1 = v;
    end
  endtask
  task automatic level(input logic [11:0] e);
    repeat (4) begin
      @(negedge clk);
      chk("level", 32'(e), 32'({b4, b3, b2, b1}));
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude;
  end
  initial begin
    {rstn, rp, shi, slo, oe_n, tst, rd, wr} = 8'h00;
    {rn, clr_n} = 2'h3;
    addr = 4'h0;
    wdat = 32'h0000_0000;
    n_fail = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, pbd_pkg::CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl_rst", 32'h0000_0000, got);
    for (int c = 0; c < 4; c++) begin
      pins(2'(c), 1'b0, 1'b0, 1'b1); // test strapped low
      clocks(3'((4'h1 << c) - 4'h1));
    end
    bus(1'b1, pbd_pkg::CTRL_OFFSET, 32'h0000_0003);
    repeat (8) @(posedge clk);
    clocks(3'h1);
    bus(1'b0, pbd_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk("applied_sel", 32'h0000_0001, {30'h0000_0000, got[1:0]});
    bus(1'b1, 4'h8, 32'h0000_0000);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, got);
    bus(1'b0, pbd_pkg::CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl", 32'h0000_0003, got);
    bus(1'b1, pbd_pkg::CTRL_OFFSET, 32'h0000_0000);
    pins(2'h3, 1'b1, 1'b0, 1'b1);
    level(12'h000);
    bus(1'b0, pbd_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk("oe_seen", 32'h0000_0001, {31'h0000_0000, got[4]});
    pins(2'h3, 1'b1, 1'b1, 1'b1);
    level(12'h000); // enable wins over bypass
    rp <= 1'b1;
    rn <= 1'b0;
    pins(2'h3, 1'b0, 1'b1, 1'b1);
    level(12'hfff);
    rp <= 1'b0;
    rn <= 1'b1;
    repeat (4) @(posedge clk);
    level(12'h000);
    pins(2'h3, 1'b0, 1'b0, 1'b0);
    clocks(3'h7); // clear held low does not stop the clocks
    bus(1'b0, pbd_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk("clr_seen", 32'h0000_0001, {31'h0000_0000, got[7]});
    chk("fb_rises", 32'h0000_0001, {31'h0000_0000, rises > 0});
    r0 = rises;
    repeat (20) @(posedge clk);
    chk("fb_rate", 32'h0000_000a, 32'(rises - r0));
    conclude;
  end
endmodule

// ### testbench/pbd_load_model.sv
/*
  Far-side model: a clocked load on one half-rate output and the board trace
  that returns it to the feedback pin.
  Assumes the fed-back output changes only on the oscillator clock edge.
*/
`timescale 1ns/1ps
module pbd_load_model (
  input wire logic ref_clk_i,
  input wire logic fed_back_i,
  output logic loop_feedback_o,
  output int rise_count_o
);
  logic last;
  // exactly one output is wired back, as a plain trace
  assign loop_feedback_o = fed_back_i;
  initial begin
    last = 1'b0;
    rise_count_o = 0;
  end
  // the load only counts rising edges it receives, like a clocked input
  always @(posedge ref_clk_i) begin
    if (fed_back_i === 1'b1 && last === 1'b0) begin
      rise_count_o <= rise_count_o + 1;
    end
    last <= fed_back_i;
  end
endmodule
